// file: rtl/measurement_trigger_sequencer.sv
// measurement trigger sequencer with ahb-lite register slave
//
// Functional notes
// RQ1 - immediate source: event detection satisfied at once, no wait
// RQ2 - external source: trigger line fall, bus trigger or key each satisfy detection; code ignores the key while CB_REMOTE is set
// RQ3 - settling delay after event detection, manual or automatic
// RQ4 - auto delay: dc volts 1ms/5ms top ranges, frequency and diode 1ms, dc current 2ms
// RQ5 - auto delay 400ms for ac functions; resistance 3..250ms table; continuity 3ms
// RQ6 - manual delay up to 99 hours 99 minutes 99.999 seconds, ms resolution
// RQ7 - manual delay type is global to every function
// RQ8 - list mode steps amplitude/frequency pair index each device action
// RQ9 - repeating filter takes configured conversions, yields one filtered reading
// RQ10 - one conversion when filter off or moving filter primed; filter feeds hold
// RQ11 - hold: first reading is seed; later readings compared against selectable window
// RQ12 - hold satisfied after programmed count (2..100) consecutive in-window readings; code raises counts below 2 to 2 but accepts up to 127
// RQ13 - out-of-window reading takes new seed and restarts count
// RQ14 - scanning: last action opens previous channel and closes next
// RQ15 - every channel transition restarts hold
// RQ16 - output trigger issued after each device action
// RQ17 - hold satisfied: beep if enabled, keep held reading until out of window
// RQ18 - remote or scanning reseeds after release; local waits for held removal
// RQ19 - command toggles between external-wait and continuous triggering
// RQ20 - default line 1 complete output, line 2 trigger input; selectable; code defaults input and output to the same line, select 0
// RQ21 - falling edge of external trigger input is the trigger event
// RQ22 - external pulses acted on only in external mode
// RQ23 - measurement-complete pulse once per completed measurement
// RQ24 - three-flop synchronised trigger input; fixed-width complete pulse
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module measurement_trigger_sequencer #(
  parameter int unsigned MS_CYCLES = trig_seq_pkg::MS_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [2:0]  external_trigger_input,
  input  wire logic        trig_key,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [31:0] conv_data,
  output logic [2:0]       measure_complete_output_n,
  output logic             beep,
  output logic [7:0]       channel,
  output logic             channel_closed,
  output logic [7:0]       list_index
);
  import trig_seq_pkg::*;

  typedef struct packed {
    seq_state_e         st;
    logic [31:0]        ctrl;
    logic [31:0]        meas;
    logic [31:0]        mdelay;
    logic [31:0]        counts;
    logic               ext_mode;
    logic [2:0]         s1;
    logic [2:0]         s2;
    logic [2:0]         s3;
    logic [2:0]         lvl;
    logic               k1;
    logic               k2;
    logic               k3;
    logic               klvl;
    logic [15:0]        pre;
    logic [28:0]        ms_left;
    logic signed [31:0] sample;
    logic signed [39:0] acc;
    logic [6:0]         fcnt;
    logic               primed;
    logic signed [31:0] avg;
    logic signed [31:0] seed;
    logic [6:0]         hcnt;
    logic               need_seed;
    logic               held;
    logic signed [31:0] reading;
    logic [7:0]         chan;
    logic               chan_closed;
    logic [7:0]         list_idx;
    logic [8:0]         pulse;
    logic [2:0]         mc_n;
    logic               beep;
    logic               conv_start;
    logic               ad_valid;
    logic               ad_write;
    logic [7:0]         ad_addr;
    logic [31:0]        hrdata;
  } regs_s;

  regs_s r;
  regs_s n;

  // manual delay in ms from hours, minutes and milliseconds fields
  function automatic logic [28:0] manual_ms(input logic [31:0] md);
    return 29'(29'(md[6:0]) * MS_PER_HOUR + 29'(md[13:7]) * MS_PER_MIN + 29'(md[30:14]));
  endfunction : manual_ms

  // average of a sum over n conversions
  function automatic logic signed [31:0] fdiv(input logic signed [39:0] s,
                                              input logic [6:0] cnt);
    return 32'(s / $signed({33'h0, cnt}));
  endfunction : fdiv

  // window test: |x - seed| within selected fraction of |seed|
  function automatic logic in_window(input logic signed [31:0] x,
                                     input logic signed [31:0] sd,
                                     input logic [1:0] w);
    logic signed [32:0] diff;
    logic [32:0]        mag;
    logic [32:0]        dmag;
    logic [32:0]        lim;
    diff = 33'(x) - 33'(sd);
    dmag = diff[32] ? 33'(-diff) : 33'(diff);
    mag  = sd[31] ? 33'(-33'(sd)) : 33'(sd);
    case (w)
      2'h0: lim = mag / 33'h2710;
      2'h1: lim = mag / 33'h3E8;
      2'h2: lim = mag / 33'h64;
      default: lim = mag / 33'hA;
    endcase
    return dmag <= lim;
  endfunction : in_window

  // out-of-range line selection falls back to the default line
  function automatic logic [1:0] line_sel(input logic [1:0] s);
    return (s == 2'h3) ? 2'h0 : s;
  endfunction : line_sel

  logic        acc_phase;
  logic        bus_trig;
  logic        ext_fall;
  logic        key_fall;
  logic        event_seen;
  logic [1:0]  in_sel;
  logic [6:0]  fc;
  logic [6:0]  hc;
  logic signed [31:0] f;
  logic        f_ok;
  logic        win;

  always_comb begin
    n = r;
    n.conv_start = 1'b0;
    n.beep       = 1'b0;
    bus_trig     = 1'b0;
    f            = r.sample;
    f_ok         = 1'b1;
    win          = 1'b0;

    // ahb data phase: writes land one cycle after the address phase
    if (r.ad_valid && r.ad_write) begin
      if (r.ad_addr == OFS_CTRL) begin
        // delay type lives in one global bit, so it covers all functions
        // RQ7 - global delay type
        n.ctrl = hwdata;
      end else if (r.ad_addr == OFS_MEAS) begin
        n.meas = hwdata;
      end else if (r.ad_addr == OFS_MDELAY) begin
        // RQ6 - manual delay fields
        n.mdelay = {1'b0, hwdata[30:0]};
      end else if (r.ad_addr == OFS_COUNTS) begin
        n.counts = hwdata;
      end else if (r.ad_addr == OFS_CMD) begin
        bus_trig = hwdata[CMD_BUS_TRIG];
        // RQ19 - toggle trigger mode
        if (hwdata[CMD_TOGGLE_EXT]) begin
          n.ext_mode = ~r.ext_mode;
        end
      end
    end

    // address phase capture; zero wait states so hreadyout stays high
    acc_phase  = hsel && hready && htrans[1];
    n.ad_valid = acc_phase;
    n.ad_write = acc_phase && hwrite;
    n.ad_addr  = acc_phase ? {haddr[7:2], 2'h0} : r.ad_addr;

    // three-flop input synchronisers; a level moves once stages 2 and 3 agree
    // RQ24 - synchronised trigger inputs
    n.s1 = external_trigger_input;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < 3; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.lvl[i] = r.s3[i];
      end
    end
    n.k1 = trig_key;
    n.k2 = r.k1;
    n.k3 = r.k2;
    if (r.k2 == r.k3) begin
      n.klvl = r.k3;
    end
    // RQ20 - selectable input line
    in_sel = line_sel(r.ctrl[CB_INSEL +: 2]);
    // RQ21 - falling edge is the event
    ext_fall = r.lvl[in_sel] && !n.lvl[in_sel];
    key_fall = r.klvl && !n.klvl;
    // front key is dead while under remote control
    // RQ2 - three event sources
    event_seen = ext_fall || bus_trig || (key_fall && !r.ctrl[CB_REMOTE]);

    fc = (r.counts[6:0] == 7'h0) ? 7'h1 : r.counts[6:0];
    hc = (r.counts[14:8] < HOLD_MIN) ? HOLD_MIN : r.counts[14:8];

    // complete pulse width counter
    if (r.pulse != 9'h0) begin
      n.pulse = r.pulse - 9'h1;
    end

    case (r.st)
      S_IDLE: begin
        if (r.ctrl[CB_RUN]) begin
          n.st = S_WAIT;
        end
      end
      S_WAIT: begin
        // RQ4 RQ5 - automatic delay table
        n.ms_left = r.ctrl[CB_MANUAL] ? manual_ms(r.mdelay)
                                      : auto_delay_ms(r.meas[3:0], r.meas[6:4]);
        n.pre = 16'h0;
        if (!r.ctrl[CB_RUN]) begin
          n.st = S_IDLE;
        // RQ1 - immediate source proceeds
        end else if (!r.ext_mode) begin
          n.st = S_DELAY;
        // RQ22 - external only in external mode
        end else if (event_seen) begin
          n.st = S_DELAY;
        end
      end
      S_DELAY: begin
        // RQ3 - settling delay in ms ticks
        if (r.ms_left == 29'h0) begin
          n.st         = S_CONV;
          n.conv_start = 1'b1;
          n.acc        = 40'h0;
          n.fcnt       = 7'h0;
        end else if (r.pre == 16'(MS_CYCLES - 1)) begin
          n.pre     = 16'h0;
          n.ms_left = r.ms_left - 29'h1;
        end else begin
          n.pre = r.pre + 16'h1;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          n.sample = conv_data;
          n.st     = S_PROC;
        end
      end
      S_PROC: begin
        // filter stage; f_ok low means more conversions are needed first
        if (r.ctrl[CB_FILT] && (r.ctrl[CB_REPEAT] || !r.primed)) begin
          // RQ9 - multi-conversion filter
          n.acc  = r.acc + 40'(r.sample);
          n.fcnt = r.fcnt + 7'h1;
          f      = fdiv(r.acc + 40'(r.sample), fc);
          f_ok   = (r.fcnt + 7'h1) >= fc;
          if (f_ok) begin
            n.acc    = 40'h0;
            n.fcnt   = 7'h0;
            n.primed = !r.ctrl[CB_REPEAT];
            n.avg    = f;
          end
        end else if (r.ctrl[CB_FILT]) begin
          // RQ10 - primed moving filter, one conversion
          f     = r.avg + fdiv(40'(r.sample) - 40'(r.avg), fc);
          n.avg = f;
        end
        win = in_window(f, r.seed, r.ctrl[CB_WIN +: 2]);
        if (!f_ok) begin
          n.st         = S_CONV;
          n.conv_start = 1'b1;
        end else if (!r.ctrl[CB_HOLD]) begin
          n.reading = f;
          n.st      = S_DONE;
        end else if (r.need_seed) begin
          // RQ11 - store seed
          n.seed       = f;
          n.hcnt       = 7'h0;
          n.need_seed  = 1'b0;
          n.st         = S_CONV;
          n.conv_start = 1'b1;
        end else if (!win) begin
          // RQ13 - reseed on out of window
          n.seed       = f;
          n.hcnt       = 7'h0;
          n.held       = 1'b0;
          n.st         = S_CONV;
          n.conv_start = 1'b1;
        end else if (r.held) begin
          // RQ17 - keep held reading
          n.st = S_DONE;
        end else if ((r.hcnt + 7'h1) >= hc) begin
          // RQ12 - count reached, release
          n.hcnt    = 7'h0;
          n.reading = f;
          n.beep    = r.ctrl[CB_BEEP];
          n.st      = S_DONE;
          // RQ18 - remote or scan reseeds
          if (r.ctrl[CB_REMOTE] || r.ctrl[CB_SCAN]) begin
            n.need_seed = 1'b1;
          end else begin
            n.held = 1'b1;
          end
        end else begin
          n.hcnt       = r.hcnt + 7'h1;
          n.st         = S_CONV;
          n.conv_start = 1'b1;
        end
      end
      S_DONE: begin
        // RQ14 - open previous, close next
        if (r.ctrl[CB_SCAN]) begin
          n.chan        = (!r.chan_closed || r.chan >= r.counts[23:16]) ? 8'h0
                                                                        : r.chan + 8'h1;
          n.chan_closed = 1'b1;
          // RQ15 - relay transition restarts hold
          n.need_seed   = 1'b1;
          n.held        = 1'b0;
          n.hcnt        = 7'h0;
        end
        // RQ8 - step list pair
        if (r.ctrl[CB_LIST]) begin
          n.list_idx = (r.list_idx >= r.counts[31:24]) ? 8'h0 : r.list_idx + 8'h1;
        end
        // RQ16 - output trigger per action
        n.pulse = 9'(PULSE_CYCLES);
        n.st    = S_WAIT;
      end
      default: n.st = S_IDLE;
    endcase

    // scanning off leaves every channel open
    if (!r.ctrl[CB_SCAN]) begin
      n.chan_closed = 1'b0;
    end
    // complete pulse drives the selected line low, others idle high
    // RQ23 - complete pulse output
    n.mc_n = 3'h7;
    if (n.pulse != 9'h0) begin
      n.mc_n[line_sel(r.ctrl[CB_OUTSEL +: 2])] = 1'b0;
    end

    // read data registered at the address phase, after this cycle's write
    n.hrdata = r.hrdata;
    if (acc_phase && !hwrite) begin
      if (haddr[7:0] == OFS_CTRL) begin
        n.hrdata = n.ctrl;
      end else if (haddr[7:0] == OFS_MEAS) begin
        n.hrdata = n.meas;
      end else if (haddr[7:0] == OFS_MDELAY) begin
        n.hrdata = n.mdelay;
      end else if (haddr[7:0] == OFS_COUNTS) begin
        n.hrdata = n.counts;
      end else if (haddr[7:0] == OFS_STATUS) begin
        n.hrdata = {4'h0, r.held, r.need_seed, r.chan_closed, n.ext_mode,
                    2'h0, r.st, r.chan, r.list_idx};
      end else if (haddr[7:0] == OFS_READING) begin
        n.hrdata = r.reading;
      end else begin
        n.hrdata = 32'h0000_0000;
      end
    end
  end

  // single state register; reset takes constants only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r        <= '0;
      r.st     <= S_IDLE;
      r.ctrl   <= CTRL_RESET;
      r.meas   <= MEAS_RESET;
      r.mdelay <= MDELAY_RESET;
      r.counts <= COUNTS_RESET;
      r.s1     <= 3'h7;
      r.s2     <= 3'h7;
      r.s3     <= 3'h7;
      r.lvl    <= 3'h7;
      r.k1     <= 1'b1;
      r.k2     <= 1'b1;
      r.k3     <= 1'b1;
      r.klvl   <= 1'b1;
      r.mc_n   <= 3'h7;
      r.need_seed <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata                    = r.hrdata;
  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign conv_start                = r.conv_start;
  assign measure_complete_output_n = r.mc_n;
  assign beep                      = r.beep;
  assign channel                   = r.chan;
  assign channel_closed            = r.chan_closed;
  assign list_index                = r.list_idx;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_immediate;
    (r.st == S_WAIT) && r.ctrl[CB_RUN] && !r.ext_mode |=> (r.st == S_DELAY);
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate source waited"); // RQ1

  property p_ext_ignored;
    (r.st == S_WAIT) && r.ctrl[CB_RUN] && r.ext_mode && !event_seen |=> (r.st == S_WAIT);
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("left wait without event"); // RQ22

  property p_fall_starts;
    (r.st == S_WAIT) && r.ctrl[CB_RUN] && r.ext_mode && ext_fall |=> (r.st == S_DELAY);
  endproperty
  a_fall_starts: assert property (p_fall_starts) else $error("trigger edge missed"); // RQ21

  property p_conv_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("conv_start too long"); // RQ10

  property p_done_pulse;
    (r.st == S_DONE) |=> (r.pulse == 9'(PULSE_CYCLES)) ##1 (measure_complete_output_n != 3'h7);
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("complete pulse missing"); // RQ16

  property p_prescale;
    (r.st == S_DELAY) |-> (r.pre < 16'(MS_CYCLES));
  endproperty
  a_prescale: assert property (p_prescale) else $error("ms prescaler overrun"); // RQ3

  property p_beep;
    beep |-> r.ctrl[CB_BEEP] && (r.st == S_DONE) && $past(r.ctrl[CB_HOLD]);
  endproperty
  a_beep: assert property (p_beep) else $error("beep without hold release"); // RQ17

  property p_channel_reseed;
    (r.st == S_DONE) && r.ctrl[CB_SCAN] |=> r.need_seed && !r.held && channel_closed;
  endproperty
  a_channel_reseed: assert property (p_channel_reseed) else $error("hold not restarted"); // RQ15

  property p_hold_count;
    (r.st == S_PROC) && r.ctrl[CB_HOLD] |-> (r.hcnt < hc);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("hold count overran"); // RQ12

  property p_pulse_end;
    (r.pulse == 9'h1) && (r.st != S_DONE) |=> (measure_complete_output_n == 3'h7);
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("complete pulse too long"); // RQ24
endmodule : measurement_trigger_sequencer
`default_nettype wire

// file: common/trig_seq_pkg.sv
// constants, types and lookups shared by the measurement trigger sequencer
package trig_seq_pkg;
  // clock and timing
  localparam longint      CLK_HZ       = 40_000_000;
  localparam longint      NS_PER_S     = 1_000_000_000;
  localparam longint      MS_NS        = 1_000_000;
  localparam longint      PULSE_NS     = 10_000;
  localparam int unsigned MS_CYCLES    = int'((MS_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  localparam int unsigned PULSE_CYCLES = int'((PULSE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
  // manual delay unit weights in milliseconds
  localparam logic [28:0] MS_PER_HOUR  = 29'h036E_E80;
  localparam logic [28:0] MS_PER_MIN   = 29'h000E_A60;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_MEAS     = 8'h04;
  localparam logic [7:0]  OFS_MDELAY   = 8'h08;
  localparam logic [7:0]  OFS_COUNTS   = 8'h0C;
  localparam logic [7:0]  OFS_CMD      = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h14;
  localparam logic [7:0]  OFS_READING  = 8'h18;
  // reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] MEAS_RESET   = 32'h0000_0000;
  localparam logic [31:0] MDELAY_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNTS_RESET = 32'h0009_050A;
  // control field positions
  localparam int CB_RUN = 0, CB_REMOTE = 2, CB_MANUAL = 3, CB_FILT = 4, CB_REPEAT = 5;
  localparam int CB_HOLD = 6, CB_BEEP = 7, CB_SCAN = 8, CB_LIST = 9, CB_WIN = 10;
  localparam int CB_INSEL = 12, CB_OUTSEL = 14;
  // command field positions
  localparam int CMD_BUS_TRIG = 0, CMD_TOGGLE_EXT = 1;
  // auto delay values in milliseconds
  localparam logic [28:0] DLY_1MS = 29'h1, DLY_2MS = 29'h2, DLY_3MS = 29'h3;
  localparam logic [28:0] DLY_5MS = 29'h5, DLY_13MS = 29'hD, DLY_25MS = 29'h19;
  localparam logic [28:0] DLY_100MS = 29'h64, DLY_150MS = 29'h96, DLY_250MS = 29'hFA;
  localparam logic [28:0] DLY_400MS = 29'h190;
  // hold count limits
  localparam logic [6:0]  HOLD_MIN = 7'h02;

  typedef enum logic [3:0] {
    dc_voltage_function  = 4'h0, ac_voltage_function = 4'h1, distortion_function = 4'h2,
    frequency_function   = 4'h3, dc_current_function = 4'h4, ac_current_function = 4'h5,
    res2w_function       = 4'h6, res4w_function      = 4'h7, continuity_function = 4'h8,
    diode_function       = 4'h9
  } meas_func_e;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01, S_WAIT = 6'h02, S_DELAY = 6'h04,
    S_CONV = 6'h08, S_PROC = 6'h10, S_DONE = 6'h20
  } seq_state_e;

  // automatic settling delay by function and range index (0 = lowest range)
  function automatic logic [28:0] auto_delay_ms(input logic [3:0] fn, input logic [2:0] rng);
    logic [28:0] d;
    d = DLY_1MS;
    case (fn)
      dc_voltage_function: d = (rng >= 3'h3) ? DLY_5MS : DLY_1MS;
      ac_voltage_function, distortion_function, ac_current_function: d = DLY_400MS;
      dc_current_function: d = DLY_2MS;
      res2w_function, res4w_function: begin
        case (rng)
          3'h0, 3'h1: d = DLY_3MS;
          3'h2: d = DLY_13MS;
          3'h3: d = DLY_25MS;
          3'h4: d = DLY_100MS;
          3'h5: d = DLY_150MS;
          default: d = DLY_250MS;
        endcase
      end
      continuity_function: d = DLY_3MS;
      default: d = DLY_1MS;
    endcase
    return d;
  endfunction : auto_delay_ms
endpackage : trig_seq_pkg

// file: testbench/trigger_scanner_model.sv
// behavioural scanner that answers complete pulses with trigger pulses
`timescale 1ns/1ps
`default_nettype none
module trigger_scanner_model #(
  parameter int SETTLE = 450,
  parameter int WIDTH  = 6
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic kick,
  input  wire logic en,
  input  wire logic complete_n,
  output var logic  trig_n
);
  int   t;
  logic last;
  // falling edge out
  // settle covers the whole complete pulse, else it retriggers and never rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t      <= 0;
      last   <= 1'b1;
      trig_n <= 1'b1;
    end else begin
      last <= complete_n;
      if (kick || (en && last && !complete_n)) t <= SETTLE + WIDTH;
      else if (t != 0) t <= t - 1;
      trig_n <= !(t != 0 && t <= WIDTH);
    end
  end
endmodule : trigger_scanner_model
`default_nettype wire

// file: testbench/measurement_trigger_sequencer_tb.sv
// self-checking bench for the measurement trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module measurement_trigger_sequencer_tb;
  import trig_seq_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trig_key = 1, conv_done = 0;
  logic kick = 0, en = 0, hreadyout, hresp, conv_start, beep, pv = 0, rnd = 0, alt = 0, pm = 1;
  logic [31:0] haddr = 0, hwdata = 0, conv_data = 0, hrdata, rd, v;
  logic [1:0]  htrans = 0, xt = 2'h3;
  logic [2:0]  mco_n;
  logic [7:0]  ch, li;
  logic        cc;
  logic [15:0] lf = 16'h0041;
  wire logic   st_n;
  int cyc = 0, n_fail = 0, check_count = 0, nc = 0, tc0, tc1, nb = 0, cb0, cb1, nf = 0;
  int sum, rf, p, m, n, f, w, r, b, k;
  initial forever #12.5 hclk = ~hclk;
  measurement_trigger_sequencer #(.MS_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_trigger_input({xt, st_n}), .trig_key(trig_key),
    .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
    .measure_complete_output_n(mco_n), .beep(beep), .channel(ch), .channel_closed(cc),
    .list_index(li));
  trigger_scanner_model scan (.hclk(hclk), .hresetn(hresetn), .kick(kick), .en(en),
    .complete_n(mco_n[0]), .trig_n(st_n));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // settling time in ms by function code and range index
  function automatic int ams(input int fn, input int rg);
    case (fn)
      0: return rg >= 3 ? 5 : 1;
      1, 2, 5: return 400;
      4: return 2;
      6, 7: return rg < 2 ? 3 : rg == 2 ? 13 : rg == 3 ? 25 : rg == 4 ? 100 : rg == 5 ? 150 : 250;
      8: return 3;
      default: return 1;
    endcase
  endfunction : ams
  task automatic results;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // single word transfer, held until hready is seen high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1);
    htrans <= 0;
    hsel   <= 0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1);
    rd = hrdata;
  endtask : bus
  task automatic wc(input int k);
    repeat (k) @(posedge hclk);
  endtask : wc
  // interval between two conversions once the new setting has settled
  task automatic per(output int q);
    n = nc + 3;
    repeat (9000) if (nc < n) @(posedge hclk);
    q = tc1 - tc0;
  endtask : per
  // converter answer and monitors, sampled away from the launching edge
  always @(negedge hclk) begin
    if (conv_start === 1) begin
      v = rnd ? {16'h0, lf} : (alt && nc[0]) ? 32'h0000_07D0 : 32'h0000_03E8;
      lf = lfsr(lf);
      sum += v;
      pv = 1;
      nc++;
      tc0 = tc1;
      tc1 = cyc;
    end
    if (beep === 1) begin
      cb0 = cb1;
      cb1 = nc;
      nb++;
    end
    if (mco_n[0] === 0 && pm === 1) nf++;
    pm = mco_n[0];
  end
  // converter drive and run limit
  always @(posedge hclk) begin
    cyc++;
    conv_done <= pv;
    conv_data <= v;
    pv = 0;
    if (cyc == 90000) begin
      n_fail++;
      results;
    end
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk("idle outputs", 5'h17, {hreadyout, hresp, mco_n});
    bus(0, OFS_COUNTS, 0);
    chk("counts reset", COUNTS_RESET, rd);
    bus(0, 8'h1C, 0);
    chk("unmapped", 0, rd);
    bus(1, OFS_MDELAY, 32'h0000_4000);
    bus(1, OFS_CTRL, 32'h0000_0009);
    per(rf);
    m = 2 + lf[3:0];
    bus(1, OFS_MDELAY, m << 14);
    per(p);
    chk("manual delay", rf + (m - 1) * 4, p);
    bus(1, OFS_CTRL, 32'h0000_0001);
    for (f = 0; f < 10; f++) begin
      r = (f == 6 || f == 7) ? lf % 7 : lf % 5;
      lf = lfsr(lf);
      bus(1, OFS_MEAS, (r << 4) | f);
      per(p);
      chk("auto delay", rf + (ams(f, r) - 1) * 4, p);
    end
    bus(1, OFS_CTRL, 32'h0000_0009);
    bus(1, OFS_CMD, 32'h0000_0002);
    wc(100);
    n = nc;
    xt <= 2'h2;
    wc(10);
    xt <= 2'h3;
    wc(200);
    chk("waiting", n, nc);
    kick <= 1;
    @(posedge hclk);
    kick <= 0;
    wc(600);
    chk("line trigger", n + 1, nc);
    trig_key <= 0;
    wc(10);
    trig_key <= 1;
    wc(500);
    chk("key trigger", n + 2, nc);
    f = nf;
    bus(1, OFS_CMD, 32'h0000_0001);
    repeat (200) if (mco_n[0] !== 0) @(negedge hclk);
    w = 0;
    while (mco_n[0] === 0 && w < 1000) begin
      w++;
      @(negedge hclk);
    end
    chk("pulse width", 400, w);
    chk("one complete", f + 1, nf);
    @(posedge hclk);
    en <= 1;
    kick <= 1;
    @(posedge hclk);
    kick <= 0;
    wc(2500);
    chk("scanner loop", 1, nf - f >= 4);
    en <= 0;
    wc(600);
    bus(1, OFS_COUNTS, 32'h0009_0104);
    bus(1, OFS_CTRL, 32'h0000_0039);
    rnd = 1;
    sum = 0;
    n = nc;
    bus(1, OFS_CMD, 32'h0000_0001);
    wc(150);
    chk("repeat convs", n + 4, nc);
    bus(0, OFS_READING, 0);
    chk("average", sum / 4, rd);
    bus(1, OFS_CTRL, 32'h0000_0019);
    bus(1, OFS_CMD, 32'h0000_0001);
    wc(150);
    n = nc;
    bus(1, OFS_CMD, 32'h0000_0001);
    wc(150);
    chk("primed moving", n + 1, nc);
    rnd = 0;
    bus(1, OFS_COUNTS, 32'h0009_0101);
    bus(1, OFS_CMD, 32'h0000_0002);
    bus(1, OFS_CTRL, 32'h0000_0CCD);
    wc(300);
    chk("hold convs", 3, cb1 - cb0);
    bus(0, OFS_READING, 0);
    chk("held reading", 32'h0000_03E8, rd);
    alt = 1;
    wc(20);
    b = nb;
    wc(300);
    chk("no release", b, nb);
    // scan and list stepping, one bus trigger per action
    bus(1, OFS_CTRL, 32'h0000_0009);
    bus(1, OFS_CMD, 32'h0000_0002);
    wc(100);
    bus(1, OFS_COUNTS, 32'h0209_0101);
    bus(1, OFS_CTRL, 32'h0000_0309);
    k = 10 + lf[2:0];
    repeat (k) begin
      bus(1, OFS_CMD, 32'h0000_0001);
      wc(100);
    end
    chk("channel", (k - 1) % 10, ch);
    chk("channel closed", 1, cc);
    chk("list pair", k % 3, li);
    results;
  end
endmodule : measurement_trigger_sequencer_tb
`default_nettype wire
